// [design/mpg_pin_ctrl.sv]
// Multifunction pin controller: enable input, pattern output or GPIO
//
// How it works
// (RULE_01) Bit 0 clear: pin is an active-high hardware enable input.
// (RULE_02) Bit 0 set with duty code: pin is pattern output.
// (RULE_03) Bits 7:6 pick bit period 1.6us, 26ms, 52ms or 105ms.
// (RULE_04) One pattern lasts 32 bit periods, one bit per period.
// (RULE_05) Duty codes: 010 half, 011 third, 100 quarter, 101/110 sixth.
// (RULE_06) After each pattern, pin floats 32*period*(1/duty-1), then repeats.
// (RULE_07) Full duty repeats pattern back to back with no dead time.
// (RULE_08) Codes 000 with bit 1 set: GPIO input, bit 2 reads pin.
// (RULE_09) Codes 000 with bit 1 clear: GPIO output driven by bit 2.
// (RULE_10) Pattern shifts out LSB first, data byte 0 bit 0 first.
// (RULE_11) Pattern bit 1 pulls pin low; bit 0 leaves pin open.
// (RULE_12) Writing 111 to bits 5:3 loads data bytes into shifter.
// (RULE_13) Any role or setting change restarts pattern from first bit.
`timescale 1ns/10ps
`default_nettype none
`include "mpg_consts.svh"

module mpg_pin_ctrl #(
   parameter int unsigned PER0_CYC = `MPG_PER0_CYC,
   parameter int unsigned PER1_CYC = `MPG_PER1_CYC,
   parameter int unsigned PER2_CYC = `MPG_PER2_CYC,
   parameter int unsigned PER3_CYC = `MPG_PER3_CYC
) (
   input  wire logic             core_clk,
   input  wire logic             srst,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   input  wire logic [7:0]       reg_addr,
   input  wire logic [7:0]       reg_wdata,
   output logic      [7:0]       reg_rdata,
   input  wire logic             pin_in,
   output logic                  pin_out,
   output logic                  pin_oe,
   output logic                  hardware_enable,
   output mpg_pkg::mpg_role_t    pin_role
);
   import mpg_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0]  ctrl_q;
   logic [31:0] pdata_q;
   logic [31:0] shift_q;
   logic [7:0]  rdata_q;
   logic        pin_s1_q;
   logic        pin_s2_q;

   wire         wr_ctrl   = reg_wr && reg_addr == `MPG_CTRL_OFFSET;
   wire [2:0]   wr_duty   = reg_wdata[`MPG_DUTY_LSB +: 3];
   wire         load_req  = wr_ctrl && wr_duty == `MPG_DUTY_LOAD;
   wire         wr_data   = reg_wr && reg_addr >= `MPG_DATA0_OFFSET
                            && reg_addr <= `MPG_DATA3_OFFSET;
   wire [1:0]   data_idx  = reg_addr[1:0];
   wire [2:0]   duty      = ctrl_q[`MPG_DUTY_LSB +: 3];
   wire [1:0]   per_sel   = ctrl_q[`MPG_PER_LSB +: 2];

   // Role decode
   wire         mode_on   = ctrl_q[`MPG_BIT_MODE];
   wire         gp_sel    = duty == `MPG_DUTY_GPIO;
   assign pin_role = !mode_on ? MPG_ROLE_ENABLE :                // [RULE_01]
                     !gp_sel  ? MPG_ROLE_PATTERN :               // [RULE_02]
                     ctrl_q[`MPG_BIT_DIR] ? MPG_ROLE_GPIN        // [RULE_08]
                                          : MPG_ROLE_GPOUT;      // [RULE_09]
   wire pat_on = pin_role == MPG_ROLE_PATTERN && duty != `MPG_DUTY_LOAD;

   // Pattern repeats per duty cycle: total frame = 32 * N periods
   function automatic logic [2:0] duty_mult(input logic [2:0] code);
      case (code)
         `MPG_DUTY_HALF:    duty_mult = 3'd2;                     // [RULE_05]
         `MPG_DUTY_THIRD:   duty_mult = 3'd3;
         `MPG_DUTY_QUARTER: duty_mult = 3'd4;
         `MPG_DUTY_SIXTH_A: duty_mult = 3'd6;
         `MPG_DUTY_SIXTH_B: duty_mult = 3'd6;
         default:           duty_mult = 3'd1;                     // [RULE_07]
      endcase
   endfunction

   function automatic logic [31:0] per_cycles(input logic [1:0] sel);
      case (sel)
         2'b00:   per_cycles = 32'(PER0_CYC);                     // [RULE_03]
         2'b01:   per_cycles = 32'(PER1_CYC);
         2'b10:   per_cycles = 32'(PER2_CYC);
         default: per_cycles = 32'(PER3_CYC);
      endcase
   endfunction

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ctrl_q <= `MPG_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         pdata_q <= 32'h0000_0000;
      end else if (wr_data) begin
         pdata_q[data_idx*8 +: 8] <= reg_wdata;
      end
   end

   // Two-flop sync of the external pin
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= pin_in;
         pin_s2_q <= pin_s1_q;
      end
   end

   wire [7:0] ctrl_view = {ctrl_q[7:3],
                           pin_role == MPG_ROLE_GPIN ? pin_s2_q     // [RULE_08]
                                                     : ctrl_q[2],
                           ctrl_q[1:0]};
   wire [7:0] rd_mux = reg_addr == `MPG_CTRL_OFFSET ? ctrl_view :
                       wr_data || (reg_addr >= `MPG_DATA0_OFFSET &&
                                   reg_addr <= `MPG_DATA3_OFFSET)
                          ? pdata_q[data_idx*8 +: 8] : 8'h00;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end
   end
   assign reg_rdata = rdata_q;

   // ------------------------------------------------------------
   // Pattern sequencer
   // ------------------------------------------------------------
   mpg_state_t  st_q;
   logic [31:0] tick_q;
   logic [7:0]  bitcnt_q;
   logic [2:0]  frame_q;
   logic        pat_oe_q;

   wire restart  = wr_ctrl;                                       // [RULE_13]
   wire per_end  = tick_q == per_cycles(per_sel) - 32'd1;
   wire last_bit = bitcnt_q == 8'(`MPG_PATTERN_BITS - 1);
   wire last_frm = frame_q == duty_mult(duty) - 3'd1;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         shift_q <= 32'h0000_0000;
      end else if (load_req) begin
         shift_q <= pdata_q;                                      // [RULE_12]
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || restart || !pat_on) begin
         st_q     <= MPG_ST_IDLE;
         tick_q   <= 32'h0000_0000;
         bitcnt_q <= 8'h00;
         frame_q  <= 3'd0;
      end else begin
         case (st_q)
            MPG_ST_IDLE: begin
               st_q <= MPG_ST_SHIFT;
            end
            MPG_ST_SHIFT, MPG_ST_DEAD: begin
               tick_q <= per_end ? 32'h0000_0000 : tick_q + 32'd1;
               if (per_end) begin
                  bitcnt_q <= last_bit ? 8'h00 : bitcnt_q + 8'd1; // [RULE_04]
                  if (last_bit) begin
                     frame_q <= last_frm ? 3'd0 : frame_q + 3'd1;
                     st_q    <= last_frm ? MPG_ST_SHIFT           // [RULE_06]
                                         : MPG_ST_DEAD;
                  end
               end
            end
            default: begin
               st_q <= MPG_ST_IDLE;
            end
         endcase
      end
   end

   // Pattern drive registered so the pad sees no bit-select decode glitches
   wire cur_bit = shift_q[bitcnt_q[4:0]];                         // [RULE_10]
   always_ff @(posedge core_clk) begin
      if (srst) begin
         pat_oe_q <= 1'b0;
      end else begin
         pat_oe_q <= st_q == MPG_ST_SHIFT && cur_bit;             // [RULE_11]
      end
   end

   // Pattern role only ever pulls low; a 0 bit just releases the pin
   assign pin_out = pin_role == MPG_ROLE_GPOUT ? ctrl_q[`MPG_BIT_GPDATA]
                                               : 1'b0;            // [RULE_09]
   assign pin_oe  = pin_role == MPG_ROLE_GPOUT ||
                    (pin_role == MPG_ROLE_PATTERN && pat_oe_q);
   assign hardware_enable = pin_role == MPG_ROLE_ENABLE && pin_s2_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_ctrl_write;
      wr_ctrl;
   endsequence

   AST_ENABLE_ROLE: assert property ( // [RULE_01]
      @(posedge core_clk) disable iff (srst)
      !mode_on |-> pin_role == MPG_ROLE_ENABLE && !pin_oe)
      else $error("enable role drives pin");
   AST_PATTERN_ROLE: assert property ( // [RULE_02]
      @(posedge core_clk) disable iff (srst)
      mode_on && !gp_sel |-> pin_role == MPG_ROLE_PATTERN)
      else $error("pattern role not selected");
   AST_PERIOD: assert property ( // [RULE_03]
      @(posedge core_clk) disable iff (srst)
      tick_q < per_cycles(per_sel))
      else $error("bit period overrun");
   AST_BITS: assert property ( // [RULE_04]
      @(posedge core_clk) disable iff (srst)
      bitcnt_q < 8'(`MPG_PATTERN_BITS))
      else $error("bit count overrun");
   AST_DUTY: assert property ( // [RULE_05]
      @(posedge core_clk) disable iff (srst)
      frame_q < duty_mult(duty) || restart)
      else $error("frame count beyond duty");
   AST_DEAD_FLOAT: assert property ( // [RULE_06]
      @(posedge core_clk) disable iff (srst)
      st_q == MPG_ST_DEAD |=> !pat_oe_q)
      else $error("pin driven in dead time");
   AST_FULL_NO_DEAD: assert property ( // [RULE_07]
      @(posedge core_clk) disable iff (srst)
      duty == `MPG_DUTY_FULL |-> st_q != MPG_ST_DEAD)
      else $error("dead time at full duty");
   AST_GPIN: assert property ( // [RULE_08]
      @(posedge core_clk) disable iff (srst)
      pin_role == MPG_ROLE_GPIN |-> !pin_oe)
      else $error("input role drives pin");
   AST_GPOUT: assert property ( // [RULE_09]
      @(posedge core_clk) disable iff (srst)
      pin_role == MPG_ROLE_GPOUT |-> pin_oe && pin_out == ctrl_q[2])
      else $error("output role level wrong");
   AST_LSB_FIRST: assert property ( // [RULE_10]
      @(posedge core_clk) disable iff (srst)
      st_q == MPG_ST_IDLE |=> bitcnt_q == 8'h00)
      else $error("pattern not from bit 0");
   AST_PULL_LOW: assert property ( // [RULE_11]
      @(posedge core_clk) disable iff (srst)
      pin_oe && pin_role == MPG_ROLE_PATTERN |-> !pin_out)
      else $error("pattern drives high");
   AST_LOAD: assert property ( // [RULE_12]
      @(posedge core_clk) disable iff (srst)
      load_req |=> shift_q == $past(pdata_q))
      else $error("shift register not loaded");
   AST_RESTART: assert property ( // [RULE_13]
      @(posedge core_clk) disable iff (srst)
      s_ctrl_write |=> st_q == MPG_ST_IDLE && bitcnt_q == 8'h00)
      else $error("no restart on control write");
endmodule
`default_nettype wire

// [shared/mpg_consts.svh]
// Constants for the multifunction pin pattern generator
`ifndef MPG_CONSTS_SVH
`define MPG_CONSTS_SVH

`define MPG_CTRL_OFFSET     8'h80
`define MPG_DATA0_OFFSET    8'h90
`define MPG_DATA3_OFFSET    8'h93
`define MPG_CTRL_RESET      8'h01

`define MPG_BIT_MODE        0
`define MPG_BIT_DIR         1
`define MPG_BIT_GPDATA      2
`define MPG_DUTY_LSB        3
`define MPG_PER_LSB         6

`define MPG_DUTY_GPIO       3'b000
`define MPG_DUTY_FULL       3'b001
`define MPG_DUTY_HALF       3'b010
`define MPG_DUTY_THIRD      3'b011
`define MPG_DUTY_QUARTER    3'b100
`define MPG_DUTY_SIXTH_A    3'b101
`define MPG_DUTY_SIXTH_B    3'b110
`define MPG_DUTY_LOAD       3'b111

`define MPG_CLK_MHZ         200
`define MPG_PER0_NS         1600
`define MPG_PER1_MS         26
`define MPG_PER2_MS         52
`define MPG_PER3_MS         105
`define MPG_PER0_CYC        ((`MPG_PER0_NS * `MPG_CLK_MHZ) / 1000)
`define MPG_PER1_CYC        (`MPG_PER1_MS * 1000 * `MPG_CLK_MHZ)
`define MPG_PER2_CYC        (`MPG_PER2_MS * 1000 * `MPG_CLK_MHZ)
`define MPG_PER3_CYC        (`MPG_PER3_MS * 1000 * `MPG_CLK_MHZ)
`define MPG_PATTERN_BITS    32

`endif

// [shared/mpg_pkg.sv]
// Types for the multifunction pin pattern generator
package mpg_pkg;
   typedef enum logic [1:0] {
      MPG_ROLE_ENABLE  = 2'b00,
      MPG_ROLE_PATTERN = 2'b01,
      MPG_ROLE_GPIN    = 2'b10,
      MPG_ROLE_GPOUT   = 2'b11
   } mpg_role_t;

   typedef enum logic [1:0] {
      MPG_ST_IDLE  = 2'b00,
      MPG_ST_SHIFT = 2'b01,
      MPG_ST_DEAD  = 2'b10
   } mpg_state_t;
endpackage

// [dv/mpg_pin_model.sv]
// Pin-side model: pull-up, optional outside driver, indicator LED
`timescale 1ns/10ps
`default_nettype none
module mpg_pin_model (
   input  wire logic pin_out,
   input  wire logic pin_oe,
   input  wire logic ext_en,
   input  wire logic ext_val,
   output logic      pin_level,
   output logic      led_on
);
   // Released line goes to the outside driver when enabled, else the pull-up, never keeps the last value
   assign pin_level = pin_oe ? pin_out : (ext_en ? ext_val : 1'b1);
   assign led_on    = pin_oe & ~pin_out;
endmodule
`default_nettype wire

// [dv/tb_multifunction_pin_pattern_gen.sv]
// Self-checking testbench for the multifunction pin controller
`timescale 1ns/10ps
`default_nettype none
module tb_multifunction_pin_pattern_gen;
   import mpg_pkg::*;
   typedef struct {
      logic [7:0] ctrl;
      logic [7:0] rd;
      mpg_role_t  role;
      logic       oe;
      logic       out;
   } mpg_row_t;
   typedef struct {
      logic [7:0] ctrl;
      int         hi;
      int         rep;
   } mpg_meas_t;
   logic       core_clk, srst, reg_wr, reg_rd, ext_en, ext_val;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   logic       pin_out, pin_oe, hardware_enable, pin_level, led_on;
   mpg_role_t  pin_role;
   int         mismatches, cmp_count, n;
   // Bit periods shortened to 4, 8, 12 and 16 cycles
   mpg_row_t   rows[6] = '{'{8'h00, 8'h00, MPG_ROLE_ENABLE, 1'b0, 1'b0},
      '{8'hFE, 8'hFE, MPG_ROLE_ENABLE, 1'b0, 1'b0},
      '{8'h03, 8'h07, MPG_ROLE_GPIN, 1'b0, 1'b0},
      '{8'h05, 8'h05, MPG_ROLE_GPOUT, 1'b1, 1'b1},
      '{8'hC1, 8'hC1, MPG_ROLE_GPOUT, 1'b1, 1'b0},
      '{8'h01, 8'h01, MPG_ROLE_GPOUT, 1'b1, 1'b0}};
   mpg_meas_t  ms[9] = '{'{8'h09, 4, 128}, '{8'h11, 4, 256},
      '{8'h19, 4, 384}, '{8'h21, 4, 512}, '{8'h29, 4, 768},
      '{8'h31, 4, 768}, '{8'h49, 8, 256}, '{8'h89, 12, 384},
      '{8'hC9, 16, 512}};

   mpg_pin_ctrl #(.PER0_CYC(4), .PER1_CYC(8), .PER2_CYC(12),
                  .PER3_CYC(16)) u_mpg_pin_ctrl (
      .core_clk(core_clk), .srst(srst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .pin_in(pin_level), .pin_out(pin_out),
      .pin_oe(pin_oe), .hardware_enable(hardware_enable),
      .pin_role(pin_role));
   mpg_pin_model u_mpg_pin_model (
      .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
      .ext_val(ext_val), .pin_level(pin_level), .led_on(led_on));

   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // ----------------------------------------
   // Bus cycles and comparisons
   // ----------------------------------------
   task automatic end_of_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string s, input logic [7:0] e, g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic chkn(input string s, input int e, g);
      cmp_count++;
      if (g != e) begin
         mismatches++;
         $display("[FAIL] %s expected %0d seen %0d", s, e, g);
      end
   endtask
   // Every open-ended wait loop goes through here so none can hang
   task automatic step;
      @(negedge core_clk);
      n++;
      if (n > 4000) begin
         mismatches++;
         end_of_test();
      end
   endtask
   // Idle cycle first so back to back calls always drop the strobe for a full cycle
   task automatic wr(input logic [7:0] a, d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      v = reg_rdata;
   endtask
   task automatic load(input logic [31:0] p);
      for (int i = 0; i < 4; i++) wr(8'h90 + 8'(i), p[8*i+:8]);
      wr(8'h80, 8'h39);
   endtask
   task automatic wait_oe;
      n = 0;
      while (pin_oe !== 1'b1) step();
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {srst, reg_wr, reg_rd, ext_en, ext_val} = 5'b10000;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      mismatches = 0;
      cmp_count = 0;
      repeat (6) @(negedge core_clk);
      srst = 1'b0;
      chk("role", MPG_ROLE_GPOUT, pin_role);
      chk("level", 8'h00, pin_level);
      rdr(8'h80);
      chk("ctrl", 8'h01, v);
      wr(8'h85, 8'h33);
      rdr(8'h85);
      chk("unmapped", 8'h00, v);
      foreach (rows[i]) begin
         wr(8'h80, rows[i].ctrl);
         repeat (3) @(negedge core_clk);
         rdr(8'h80);
         chk("ctrl", rows[i].rd, v);
         chk("role", rows[i].role, pin_role);
         chk("oe", rows[i].oe, pin_oe);
         if (rows[i].oe) chk("level", rows[i].out, pin_level);
      end
      wr(8'h80, 8'h00);
      ext_en = 1'b1;
      for (int b = 0; b < 2; b++) begin
         ext_val = b[0];
         repeat (4) @(negedge core_clk);
         chk("hardware_enable_input", b[0], hardware_enable);
      end
      ext_val = 1'b0;
      wr(8'h80, 8'h03);
      repeat (4) @(negedge core_clk);
      rdr(8'h80);
      chk("gpin", 8'h03, v);
      chk("hardware_enable_input", 8'h00, hardware_enable);
      ext_en = 1'b0;
      load(32'h8000_00A5);
      wr(8'h80, 8'h11);
      wait_oe();
      @(negedge core_clk);
      for (int i = 0; i < 32; i++) begin
         chk("bit", (32'h8000_00A5 >> i) & 1, pin_oe);
         if (pin_oe === 1'b1) chk("led", 8'h01, led_on);
         repeat (4) @(negedge core_clk);
      end
      load(32'h0000_0001);
      foreach (ms[i]) begin
         wr(8'h80, 8'h39);
         wr(8'h80, ms[i].ctrl);
         wait_oe();
         n = 0;
         while (pin_oe === 1'b1) step();
         chkn("bit_time", ms[i].hi, n);
         while (pin_oe !== 1'b1) step();
         chkn("repeat", ms[i].rep, n);
      end
      rdr(8'h90);
      chk("pdata", 8'h01, v);
      // Reset in mid-pattern must bring back the power-on state
      srst = 1'b1;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      chk("role", MPG_ROLE_GPOUT, pin_role);
      chk("level", 8'h00, pin_level);
      rdr(8'h90);
      chk("pdata", 8'h00, v);
      rdr(8'h80);
      chk("ctrl", 8'h01, v);
      end_of_test();
   end
endmodule
`default_nettype wire
